// [design/ffc_pkg.sv]
// Constants, pin positions and default offset table for the FIFO port control block.
// Assumes all pins are sampled by one fast system clock.
package ffc_pkg;

    // ************************************************************
    // Data layout
    // ************************************************************
    localparam int FFC_BYTE_W = 9;
    localparam int FFC_LANES = 4;
    localparam int FFC_DATA_W = 36;
    localparam int FFC_OFS_FIELD = 16;

    // ************************************************************
    // Positions of the sampled pins in the synchroniser vector
    // ************************************************************
    localparam int FFC_P_WCLK = 0;
    localparam int FFC_P_RCLK = 1;
    localparam int FFC_P_MRS = 2;
    localparam int FFC_P_SI = 3;
    localparam int FFC_P_WRITE_ASYNC_SELECT_N = 4;
    localparam int FFC_P_READ_ASYNC_SELECT_N = 5;
    localparam int FFC_P_WEN = 6;
    localparam int FFC_P_REN = 7;
    localparam int FFC_P_OE = 8;
    localparam int FFC_P_SEN = 9;
    localparam int FFC_P_LD = 10;
    localparam int FFC_P_FS0 = 11;
    localparam int FFC_P_FS1 = 12;
    localparam int FFC_P_BM = 13;
    localparam int FFC_P_IW = 14;
    localparam int FFC_P_OW = 15;
    localparam int FFC_P_DATA = 16;
    localparam int FFC_P_W = FFC_P_DATA + FFC_DATA_W;

    // ************************************************************
    // Port widths in bytes and width select codes {bm, iw, ow}
    // ************************************************************
    localparam logic [2:0] FFC_B36 = 3'h4;
    localparam logic [2:0] FFC_B18 = 3'h2;
    localparam logic [2:0] FFC_B9 = 3'h1;
    localparam logic [2:0] FFC_SEL_36_18 = 3'h4;
    localparam logic [2:0] FFC_SEL_36_9 = 3'h5;
    localparam logic [2:0] FFC_SEL_18_36 = 3'h6;
    localparam logic [2:0] FFC_SEL_9_36 = 3'h7;

    // ************************************************************
    // Default offsets, indexed by {offset_load, sel1, sel0}
    // ************************************************************
    localparam logic [15:0] FFC_DEF_OFS [8] = '{16'h0007, 16'h001f, 16'h003f, 16'h007f,
                                                16'h00ff, 16'h01ff, 16'h03ff, 16'h000f};

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [FFC_DATA_W-1:0] FFC_Q_RST = 36'h000000000;

endpackage // ffc_pkg

// [design/ffc_port_ctrl.sv]
// Port-side control of a dual-clock 36-bit FIFO, built on one system clock.
// Assumes write and read clocks arrive as slow pins that the system clock samples.
//
// What this block does
// - Mode low at reset: empty/full flags
// - Mode high at reset: output-valid/input-space flags
// - Mode pin becomes serial offset input after reset
// - Sync write stores data when enabled, not full
// - Write enable ignored while full
// - Stopped write clock freezes write-side flags
// - Async write stores on each strobe edge
// - Full clears two write clocks after read
// - Sync read loads output register when enabled
// - Read enable high holds output register
// - Stopped read clock freezes read-side flags
// - Empty flag rises two read clocks after write
// - First word falls through on third edge
// - Output-valid drops only on a true read
// - Async read loads on each strobe edge
// - Serial enable and load low shift offsets
// - Serial enable high keeps offsets
// - Output enable low drives data outputs
// - Load and selects choose default and method
// - Load low accesses offsets; reads parallel
// - Width pins set bus sizes; flags count units
`timescale 1ns/1ps

module ffc_port_ctrl
    import ffc_pkg::*;
#(
    parameter int DEPTH = 1024
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic master_reset_n_i,
    input wire logic fallthrough_or_serial_in_i,
    input wire logic write_async_select_n_i,
    input wire logic read_async_select_n_i,
    input wire logic write_clock_i,
    input wire logic write_enable_n_i,
    input wire logic [FFC_DATA_W-1:0] data_in_i,
    input wire logic read_clock_i,
    input wire logic read_enable_n_i,
    input wire logic output_enable_n_i,
    input wire logic serial_load_enable_n_i,
    input wire logic offset_load_n_i,
    input wire logic default_offset_sel0_i,
    input wire logic default_offset_sel1_i,
    input wire logic bus_match_select_i,
    input wire logic input_width_select_i,
    input wire logic output_width_select_i,
    output logic [FFC_DATA_W-1:0] data_out_o,
    output logic data_out_oe_o,
    output logic full_indicator_n_o,
    output logic empty_indicator_n_o,
    output logic almost_full_n_o,
    output logic almost_empty_n_o,
    output logic half_full_n_o
);

    localparam int CAP_B = DEPTH * FFC_LANES;
    localparam int AW = $clog2(CAP_B);
    localparam int PW = AW + 1;
    localparam int OFS_W = PW;
    localparam logic [PW-1:0] CAP = PW'(CAP_B);

    // ************************************************************
    // Pin synchroniser and clock edge detection
    // ************************************************************
    logic [FFC_P_W-1:0] pins_raw;
    logic [FFC_P_W-1:0] pins_m;
    logic [FFC_P_W-1:0] pins_s;
    logic wclk_d;
    logic rclk_d;
    logic w_edge;
    logic r_edge;

    assign pins_raw = {data_in_i, output_width_select_i, input_width_select_i, bus_match_select_i,
                       default_offset_sel1_i, default_offset_sel0_i, offset_load_n_i,
                       serial_load_enable_n_i, output_enable_n_i, read_enable_n_i, write_enable_n_i,
                       read_async_select_n_i, write_async_select_n_i, fallthrough_or_serial_in_i,
                       master_reset_n_i, read_clock_i, write_clock_i};

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pins_m <= '0;
            pins_s <= '0;
            wclk_d <= 1'b0;
            rclk_d <= 1'b0;
        end else begin
            pins_m <= pins_raw;
            pins_s <= pins_m;
            wclk_d <= pins_s[FFC_P_WCLK];
            rclk_d <= pins_s[FFC_P_RCLK];
        end
    end

    logic mrs_s;
    logic si_s;
    logic wen_s;
    logic ren_s;
    logic sen_s;
    logic ld_s;
    logic [FFC_DATA_W-1:0] din_s;

    assign mrs_s = pins_s[FFC_P_MRS];
    assign si_s = pins_s[FFC_P_SI];
    assign wen_s = pins_s[FFC_P_WEN];
    assign ren_s = pins_s[FFC_P_REN];
    assign sen_s = pins_s[FFC_P_SEN];
    assign ld_s = pins_s[FFC_P_LD];
    assign din_s = pins_s[FFC_P_DATA +: FFC_DATA_W];
    assign w_edge = pins_s[FFC_P_WCLK] && !wclk_d;
    assign r_edge = pins_s[FFC_P_RCLK] && !rclk_d;

    // ************************************************************
    // Configuration caught while master reset is held
    // ************************************************************
    logic first_word_fallthrough;
    logic async_w;
    logic async_r;
    logic serial_mode;
    logic [2:0] win_b;
    logic [2:0] wout_b;
    logic [1:0] ushift;
    logic [2:0] sel_pins;
    logic [2:0] next_win;
    logic [2:0] next_wout;

    assign sel_pins = {pins_s[FFC_P_BM], pins_s[FFC_P_IW], pins_s[FFC_P_OW]};

    always_comb begin
        next_win = FFC_B36;
        next_wout = FFC_B36;
        if (sel_pins == FFC_SEL_36_18) next_wout = FFC_B18;
        if (sel_pins == FFC_SEL_36_9) next_wout = FFC_B9;
        if (sel_pins == FFC_SEL_18_36) next_win = FFC_B18;
        if (sel_pins == FFC_SEL_9_36) next_win = FFC_B9;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            first_word_fallthrough <= 1'b0;
            async_w <= 1'b0;
            async_r <= 1'b0;
            win_b <= FFC_B36;
            wout_b <= FFC_B36;
            ushift <= 2'h2;
        end else if (!mrs_s) begin
            first_word_fallthrough <= si_s;
            async_w <= !pins_s[FFC_P_WRITE_ASYNC_SELECT_N];
            async_r <= !pins_s[FFC_P_READ_ASYNC_SELECT_N];
            win_b <= next_win;
            wout_b <= next_wout;
            ushift <= (next_win == FFC_B9 || next_wout == FFC_B9) ? 2'h0 :
                      (next_win == FFC_B18 || next_wout == FFC_B18) ? 2'h1 : 2'h2;
        end
    end

    // ************************************************************
    // Offset registers
    // ************************************************************
    logic [OFS_W-1:0] empty_ofs;
    logic [OFS_W-1:0] full_ofs;
    logic [2:0] def_idx;

    assign def_idx = {ld_s, pins_s[FFC_P_FS1], pins_s[FFC_P_FS0]};

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            empty_ofs <= OFS_W'(FFC_DEF_OFS[0]);
            full_ofs <= OFS_W'(FFC_DEF_OFS[0]);
            serial_mode <= 1'b0;
        end else if (!mrs_s) begin
            empty_ofs <= OFS_W'(FFC_DEF_OFS[def_idx]);
            full_ofs <= OFS_W'(FFC_DEF_OFS[def_idx]);
            serial_mode <= ld_s;
        end else if (w_edge && !ld_s) begin
            if (serial_mode && !sen_s) begin
                {full_ofs, empty_ofs} <= {full_ofs[OFS_W-2:0], empty_ofs, si_s};
            end else if (!serial_mode && !wen_s) begin
                empty_ofs <= din_s[OFS_W-1:0];
                full_ofs <= din_s[FFC_OFS_FIELD +: OFS_W];
            end
        end
    end

    // ************************************************************
    // Write side
    // ************************************************************
    logic [FFC_BYTE_W-1:0] mem [CAP_B];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] rd_w1;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_cnt_w;
    logic [PW-1:0] units_w;
    logic [PW-1:0] cap_u;
    logic ff_pin;
    logic almost_full_n;
    logic full_now;
    logic next_full;
    logic wr_go;

    assign cap_u = CAP >> ushift;
    assign full_now = first_word_fallthrough ? ff_pin : !ff_pin;
    assign wr_go = w_edge && ld_s && (async_w || !wen_s) && !full_now;
    assign next_wr_ptr = wr_go ? wr_ptr + PW'(win_b) : wr_ptr;
    assign next_cnt_w = next_wr_ptr - rd_w1;
    assign next_full = next_cnt_w > CAP - PW'(win_b);
    assign units_w = next_cnt_w >> ushift;

    always_ff @(posedge clk_i) begin
        if (!nrst_i || !mrs_s) begin
            wr_ptr <= '0;
            rd_w1 <= '0;
            ff_pin <= !si_s;
            almost_full_n <= 1'b1;
        end else if (w_edge) begin
            wr_ptr <= next_wr_ptr;
            rd_w1 <= rd_ptr;
            ff_pin <= first_word_fallthrough ? next_full : !next_full;
            almost_full_n <= !(units_w >= cap_u - full_ofs);
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_go) begin
            for (int k = 0; k < FFC_LANES; k++) begin
                if (k < int'(win_b)) begin
                    mem[AW'(wr_ptr + PW'(k))] <= din_s[k*FFC_BYTE_W +: FFC_BYTE_W];
                end
            end
        end
    end

    // ************************************************************
    // Read side
    // ************************************************************
    logic [PW-1:0] wr_r1;
    logic [PW-1:0] wr_r2;
    logic [PW-1:0] next_rd_ptr;
    logic [PW-1:0] avail_r;
    logic [PW-1:0] units_r;
    logic [FFC_DATA_W-1:0] rd_word;
    logic [FFC_DATA_W-1:0] ofs_word;
    logic [FFC_DATA_W-1:0] data_q;
    logic ef_pin;
    logic out_valid;
    logic almost_empty_n;
    logic hf_n;
    logic rd_go;
    logic ren_ok;
    logic ofs_rd;

    generate
        for (genvar k = 0; k < FFC_LANES; k++) begin : g_lane
            assign rd_word[k*FFC_BYTE_W +: FFC_BYTE_W] =
                (k < int'(wout_b)) ? mem[AW'(rd_ptr + PW'(k))] : '0;
        end
    endgenerate

    always_comb begin
        ofs_word = '0;
        ofs_word[OFS_W-1:0] = empty_ofs;
        ofs_word[FFC_OFS_FIELD +: OFS_W] = full_ofs;
    end

    assign avail_r = wr_r2 - rd_ptr;
    assign ren_ok = async_r || !ren_s;
    assign ofs_rd = r_edge && !ld_s && !ren_s;
    assign rd_go = r_edge && ld_s && (first_word_fallthrough ? ((!out_valid || ren_ok) && avail_r >= PW'(wout_b))
                                           : (ef_pin && ren_ok));
    assign next_rd_ptr = rd_go ? rd_ptr + PW'(wout_b) : rd_ptr;
    assign units_r = (wr_r2 - next_rd_ptr) >> ushift;

    always_ff @(posedge clk_i) begin
        if (!nrst_i || !mrs_s) begin
            rd_ptr <= '0;
            wr_r1 <= '0;
            wr_r2 <= '0;
            ef_pin <= 1'b0;
            out_valid <= 1'b0;
            almost_empty_n <= 1'b0;
        end else if (r_edge) begin
            rd_ptr <= next_rd_ptr;
            wr_r1 <= wr_ptr;
            wr_r2 <= wr_r1;
            ef_pin <= (wr_r1 - next_rd_ptr) >= PW'(wout_b);
            if (rd_go) begin
                out_valid <= 1'b1;
            end else if (ld_s && ren_ok) begin
                out_valid <= 1'b0;
            end
            almost_empty_n <= !(units_r <= PW'(empty_ofs));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i || !mrs_s) begin
            data_q <= FFC_Q_RST;
        end else if (ofs_rd) begin
            data_q <= ofs_word;
        end else if (rd_go) begin
            data_q <= rd_word;
        end
    end

    // Write edges may only lower half-full; read edges may only raise it
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !mrs_s) begin
            hf_n <= 1'b1;
        end else if (w_edge && units_w > (cap_u >> 1)) begin
            hf_n <= 1'b0;
        end else if (r_edge && units_r <= (cap_u >> 1)) begin
            hf_n <= 1'b1;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign data_out_o = data_q;
    assign data_out_oe_o = !pins_s[FFC_P_OE];
    assign full_indicator_n_o = ff_pin;
    assign empty_indicator_n_o = first_word_fallthrough ? !out_valid : ef_pin;
    assign almost_full_n_o = almost_full_n;
    assign almost_empty_n_o = almost_empty_n;
    assign half_full_n_o = hf_n;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i || !mrs_s);

    sequence s_last_read;
        first_word_fallthrough && out_valid && r_edge && ld_s && !ren_s && avail_r < PW'(wout_b);
    endsequence

    a_full_blocks_write: assert property ((w_edge && full_now) |=> $stable(wr_ptr))
        else $error("write taken while full");
    a_write_advances: assert property ((w_edge && ld_s && !wen_s && !full_now) |=>
        wr_ptr == $past(wr_ptr) + PW'($past(win_b)))
        else $error("enabled write did not advance pointer");
    a_hold_on_ren: assert property ((r_edge && ld_s && ren_s && !async_r && (!first_word_fallthrough || out_valid)) |=>
        $stable(data_q))
        else $error("output register changed without read");
    a_wflags_frozen: assert property (!w_edge |=> $stable(ff_pin) && $stable(almost_full_n) && !$fell(hf_n))
        else $error("write-side flag moved without write clock");
    a_rflags_frozen: assert property (!r_edge |=> $stable(ef_pin) && $stable(out_valid) && $stable(almost_empty_n)
        && !$rose(hf_n))
        else $error("read-side flag moved without read clock");
    a_serial_hold: assert property ((w_edge && serial_mode && sen_s) |=> $stable(empty_ofs) && $stable(full_ofs))
        else $error("offsets changed with serial enable high");
    a_serial_shift: assert property ((w_edge && serial_mode && !sen_s && !ld_s) |=>
        empty_ofs[0] == $past(si_s))
        else $error("serial bit not shifted in");
    a_empty_ignore: assert property ((r_edge && !first_word_fallthrough && !ef_pin) |=> $stable(rd_ptr))
        else $error("read taken while empty");
    a_valid_drops: assert property (s_last_read |=> !out_valid ##1 $stable(data_q))
        else $error("output-valid not dropped by true read");

endmodule // ffc_port_ctrl

// [testbench/ffc_sys_model.sv]
// Behavioural writer and reader facing the FIFO's slow clock, enable and data pins.
// Assumes the bench calls wr and rd one at a time; each link cycle lasts 8 system clocks.
`timescale 1ns/1ps

module ffc_sys_model
    import ffc_pkg::*;
(
    input wire logic clk_i,
    input wire logic wr_async_n_i,
    input wire logic rd_async_n_i,
    output logic write_clock_o,
    output logic write_enable_n_o,
    output logic [FFC_DATA_W-1:0] data_in_o,
    output logic read_clock_o,
    output logic read_enable_n_o
);
    // ************************************************************
    // Link cycles
    // ************************************************************
    initial begin
        write_clock_o = 1'b0;
        read_clock_o = 1'b0;
        write_enable_n_o = 1'b1;
        read_enable_n_o = 1'b1;
        data_in_o = '0;
    end

    // Clock pins stand still between cycles; released data shows its inverse
    task automatic wr(input logic en_n, input logic [FFC_DATA_W-1:0] d);
        @(posedge clk_i);
        write_enable_n_o <= en_n;
        data_in_o <= d;
        repeat (2) @(posedge clk_i);
        write_clock_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        write_clock_o <= 1'b0;
        @(posedge clk_i);
        write_enable_n_o <= wr_async_n_i;
        data_in_o <= ~d;
        #1;
    endtask

    task automatic rd(input logic en_n);
        @(posedge clk_i);
        read_enable_n_o <= en_n;
        repeat (2) @(posedge clk_i);
        read_clock_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        read_clock_o <= 1'b0;
        @(posedge clk_i);
        read_enable_n_o <= rd_async_n_i;
        #1;
    endtask
endmodule // ffc_sys_model

// [testbench/fifo_port_control_pins_tb.sv]
// Self-checking bench of the FIFO port control block, DEPTH set to 4.
// Assumes ffc_sys_model drives the write and read side pins.
`timescale 1ns/1ps

`define FFC_CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected %s: expected %h seen %h", nm, exp, got); end end

module fifo_port_control_pins_tb import ffc_pkg::*;;
    typedef struct packed {
        logic wr;
        logic en_n;
        logic [FFC_DATA_W-1:0] d;
        logic [FFC_DATA_W-1:0] q;
        logic cf;
        logic e;
        logic f;
    } ffc_row_t;

    // Standard timing: write, read, fill to full, refuse, recover, drain
    localparam ffc_row_t ROWS [20] = '{
        '{1, 0, 36'h111111111, 36'h0, 1, 0, 1}, '{0, 1, 36'h0, 36'h0, 1, 0, 1},
        '{0, 1, 36'h0, 36'h0, 1, 1, 1}, '{0, 0, 36'h0, 36'h111111111, 0, 0, 0},
        '{0, 1, 36'h0, 36'h111111111, 1, 0, 1}, '{1, 0, 36'h222222222, 36'h111111111, 0, 0, 0},
        '{1, 0, 36'h333333333, 36'h111111111, 0, 0, 0}, '{1, 0, 36'h444444444, 36'h111111111, 0, 0, 0},
        '{1, 0, 36'h555555555, 36'h111111111, 0, 0, 0}, '{1, 0, 36'h666666666, 36'h111111111, 1, 0, 0},
        '{0, 1, 36'h0, 36'h111111111, 0, 0, 0}, '{0, 1, 36'h0, 36'h111111111, 1, 1, 0},
        '{0, 0, 36'h0, 36'h222222222, 1, 1, 0}, '{1, 1, 36'h0, 36'h222222222, 0, 0, 0},
        '{1, 1, 36'h0, 36'h222222222, 1, 1, 1}, '{0, 0, 36'h0, 36'h333333333, 0, 0, 0},
        '{0, 0, 36'h0, 36'h444444444, 0, 0, 0}, '{0, 0, 36'h0, 36'h555555555, 0, 0, 0},
        '{0, 1, 36'h0, 36'h555555555, 1, 0, 1}, '{0, 0, 36'h0, 36'h555555555, 1, 0, 1}};
    localparam logic [FFC_DATA_W-1:0] WORD = {9'h104, 9'h103, 9'h102, 9'h101};
    // Narrow width pairings: select code, bytes in, bytes out, mask of one output unit
    localparam logic [2:0] WSEL [4] = '{FFC_SEL_36_18, FFC_SEL_36_9, FFC_SEL_18_36, FFC_SEL_9_36};
    localparam int WIN [4] = '{4, 4, 2, 1};
    localparam int WOUT [4] = '{2, 1, 4, 4};
    localparam logic [FFC_DATA_W-1:0] LMASK [4] = '{36'h00003ffff, 36'h0000001ff, 36'hfffffffff, 36'hfffffffff};

    logic clk_i, nrst_i, mrs_n, si, write_async_select_n_n, read_async_select_n_n, wclk, wen_n, rclk, ren_n, oe_n, sen_n, ld_n;
    logic sel0, sel1, bm, iw, ow, q_oe, full_n, empty_n, af_n, ae_n, hf_n;
    logic [FFC_DATA_W-1:0] din, q;
    int miscompares = 0;
    int checks_done = 0;

    ffc_port_ctrl #(.DEPTH(4)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .master_reset_n_i(mrs_n), .fallthrough_or_serial_in_i(si),
        .write_async_select_n_i(write_async_select_n_n), .read_async_select_n_i(read_async_select_n_n), .write_clock_i(wclk),
        .write_enable_n_i(wen_n), .data_in_i(din), .read_clock_i(rclk), .read_enable_n_i(ren_n),
        .output_enable_n_i(oe_n), .serial_load_enable_n_i(sen_n), .offset_load_n_i(ld_n),
        .default_offset_sel0_i(sel0), .default_offset_sel1_i(sel1), .bus_match_select_i(bm),
        .input_width_select_i(iw), .output_width_select_i(ow), .data_out_o(q), .data_out_oe_o(q_oe),
        .full_indicator_n_o(full_n), .empty_indicator_n_o(empty_n), .almost_full_n_o(af_n),
        .almost_empty_n_o(ae_n), .half_full_n_o(hf_n));

    ffc_sys_model sysm (
        .clk_i(clk_i), .wr_async_n_i(write_async_select_n_n), .rd_async_n_i(read_async_select_n_n), .write_clock_o(wclk),
        .write_enable_n_o(wen_n), .data_in_o(din), .read_clock_o(rclk), .read_enable_n_o(ren_n));

    // ************************************************************
    // Clock, verdict and watchdog
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        $display("checks %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #500000;
        miscompares++;
        print_verdict();
    end

    // Master reset with straps; checks the mode flags while it is held
    task automatic mrst(input logic m, input logic l, input logic wa, input logic ra, input logic [2:0] w);
        @(posedge clk_i);
        mrs_n <= 1'b0;
        si <= m;
        ld_n <= l;
        write_async_select_n_n <= wa;
        read_async_select_n_n <= ra;
        {bm, iw, ow} <= w;
        repeat (6) @(posedge clk_i);
        #1;
        `FFC_CHK("mode flags", {~m, m}, {full_n, empty_n})
        `FFC_CHK("reset state", {3'b011, FFC_Q_RST}, {ae_n, af_n, hf_n, q})
        @(posedge clk_i);
        mrs_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        si <= 1'b0;
        ld_n <= 1'b1;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        {nrst_i, mrs_n, si, write_async_select_n_n, read_async_select_n_n, oe_n, sen_n, ld_n, sel0, sel1, bm, iw, ow} = 13'h0f8;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        mrst(1'b0, 1'b1, 1'b1, 1'b1, 3'h0);
        for (int i = 0; i < 20; i++) begin
            if (ROWS[i].wr) sysm.wr(ROWS[i].en_n, ROWS[i].d);
            else sysm.rd(ROWS[i].en_n);
            `FFC_CHK("data_out", ROWS[i].q, q)
            if (ROWS[i].cf) `FFC_CHK("flags", {ROWS[i].e, ROWS[i].f}, {empty_n, full_n})
        end
        $display("test standard table finished");
        mrst(1'b1, 1'b1, 1'b1, 1'b1, 3'h0);
        sysm.wr(1'b0, 36'h111111111);
        sysm.rd(1'b1);
        sysm.rd(1'b1);
        `FFC_CHK("fall through early", {1'b1, 36'h0}, {empty_n, q})
        sysm.rd(1'b1);
        `FFC_CHK("fall through word", {1'b0, 36'h111111111}, {empty_n, q})
        sysm.rd(1'b0);
        sysm.rd(1'b0);
        `FFC_CHK("last word read", {1'b1, 36'h111111111}, {empty_n, q})
        $display("test fall through finished");
        mrst(1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
        sysm.wr(1'b0, 36'h111111111);
        sysm.wr(1'b0, 36'h222222222);
        repeat (4) sysm.rd(1'b0);
        `FFC_CHK("async strobes", 36'h222222222, q)
        $display("test async finished");
        for (int c = 0; c < 4; c++) begin
            mrst(1'b0, 1'b1, 1'b1, 1'b1, WSEL[c]);
            for (int j = 0; j < 4 / WIN[c]; j++) begin
                sysm.wr(1'b0, WORD >> (9 * WIN[c] * j));
            end
            sysm.rd(1'b1);
            sysm.rd(1'b1);
            for (int i = 0; i < 4 / WOUT[c]; i++) begin
                sysm.rd(1'b0);
                `FFC_CHK("byte lane", (WORD >> (9 * WOUT[c] * i)) & LMASK[c], q & LMASK[c])
            end
        end
        $display("test bus width finished");
        // Parallel method: the four default offsets picked by the select pins
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_i);
            {sel1, sel0} <= 2'(s);
            mrst(1'b0, 1'b0, 1'b1, 1'b1, 3'h0);
            @(posedge clk_i);
            ld_n <= 1'b0;
            sysm.rd(1'b0);
            `FFC_CHK("default offsets", {2{FFC_DEF_OFS[s][4:0]}}, {q[20:16], q[4:0]})
        end
        $display("test default offsets finished");
        mrst(1'b0, 1'b0, 1'b1, 1'b1, 3'h0);
        @(posedge clk_i);
        ld_n <= 1'b0;
        sysm.wr(1'b0, 36'h000020001);
        sysm.rd(1'b0);
        `FFC_CHK("parallel offsets", 4'h9, {q[17:16], q[1:0]})
        mrst(1'b0, 1'b1, 1'b1, 1'b1, 3'h0);
        @(posedge clk_i);
        ld_n <= 1'b0;
        sen_n <= 1'b0;
        si <= 1'b1;
        sysm.wr(1'b1, 36'h0);
        @(posedge clk_i);
        si <= 1'b0;
        sysm.wr(1'b1, 36'h0);
        @(posedge clk_i);
        sen_n <= 1'b1;
        si <= 1'b1;
        sysm.wr(1'b1, 36'h0);
        sysm.rd(1'b0);
        `FFC_CHK("serial offsets", 2'h2, q[1:0])
        $display("test offsets finished");
        @(posedge clk_i);
        ld_n <= 1'b1;
        oe_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        `FFC_CHK("output enable off", 1'b0, q_oe)
        @(posedge clk_i);
        oe_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        `FFC_CHK("output enable on", 1'b1, q_oe)
        $display("test output enable finished");
        print_verdict();
    end
endmodule // fifo_port_control_pins_tb
